/* qfc_regs.svh */
// register offsets, field positions, reset values and timing for the fast counter
`ifndef QFC_REGS_SVH
`define QFC_REGS_SVH
`define QFC_ADDR_W 8
`define QFC_OFS_CTRL 8'h00
`define QFC_OFS_COUNT 8'h04
`define QFC_OFS_PRESET 8'h08
`define QFC_OFS_STATUS 8'h0C
`define QFC_OFS_IRQ_MASK 8'h10
`define QFC_CTRL_ASSIGN 0
`define QFC_CTRL_MODE_LSB 1
`define QFC_CTRL_MODE_MSB 3
`define QFC_CTRL_TIMER 4
`define QFC_CTRL_LEN16 5
`define QFC_CTRL_SMASK 6
`define QFC_CTRL_SCLEAR 7
`define QFC_CTRL_USE_LSB 8
`define QFC_CTRL_USE_MSB 11
`define QFC_CTRL_INV_LSB 12
`define QFC_CTRL_INV_MSB 15
`define QFC_CTRL_RESET 32'h0000_0000
`define QFC_ST_MATCH 0
`define QFC_ST_MASK_LVL 8
`define QFC_ST_CLEAR_LVL 9
`define QFC_PINS 4
`define QFC_PIN_A 0
`define QFC_PIN_B 1
`define QFC_PIN_M 2
`define QFC_PIN_C 3
`define QFC_HALF_W 16
`define QFC_RESP_OKAY 2'h0
`define QFC_RESP_SLVERR 2'h2
`define QFC_CLK_NS 5
`define QFC_TICK_NS 1000
`define QFC_TICK_CYC ((`QFC_TICK_NS + `QFC_CLK_NS - 1) / `QFC_CLK_NS)
`endif

/* qfc_pkg.sv */
// types and shared decode for the fast counter
package qfc_pkg;
`include "qfc_regs.svh"
    // counting modes in field order
    typedef enum logic [2:0] {
        updn_rise_mode,
        updn_both_mode,
        pdir_rise_mode,
        pdir_both_mode,
        quad_x1_mode,
        quad_x2_mode,
        quad_x3_mode,
        quad_x4_mode
    } qfc_mode_e;

    // true for an implemented register offset
    function automatic logic qfc_addr_known(input logic [`QFC_ADDR_W-1:0] a);
        return (a == `QFC_OFS_CTRL) || (a == `QFC_OFS_COUNT) ||
            (a == `QFC_OFS_PRESET) || (a == `QFC_OFS_STATUS) ||
            (a == `QFC_OFS_IRQ_MASK);
    endfunction
endpackage

/* qfc_if.sv */
// carriers between the counter core, input conditioner and bus slave
`timescale 1ns/100ps
`include "qfc_regs.svh"
interface qfc_pin_if;
    logic [`QFC_PINS-1:0] lvl;
    logic [`QFC_PINS-1:0] rise;
    logic [`QFC_PINS-1:0] fall;
    modport cond (output lvl, output rise, output fall);
    modport core (input lvl, input rise, input fall);
endinterface

interface qfc_reg_if;
    logic wr;
    logic [`QFC_ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic werr;
    logic [`QFC_ADDR_W-1:0] raddr;
    logic [31:0] rdata;
    logic rerr;
    modport slave (output wr, waddr, wdata, wstrb, raddr, input werr, rdata, rerr);
    modport core (input wr, waddr, wdata, wstrb, raddr, output werr, rdata, rerr);
endinterface

/* qfc_cond.sv */
// input conditioner: synchroniser, inversion, use gate and edge detect
`timescale 1ns/100ps
`include "qfc_regs.svh"
module qfc_cond #(
    parameter int N = `QFC_PINS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [N-1:0] pin,
    input wire logic [N-1:0] use_sel,
    input wire logic [N-1:0] inv_sel,
    qfc_pin_if.cond sig
);
    if (N != `QFC_PINS) begin : g_chk
        $error("qfc_cond: N must match the pin carrier width");
    end

    logic [N-1:0] meta_r;
    logic [N-1:0] sync_r;
    logic [N-1:0] prev_r;
    logic [N-1:0] lvl;

    for (genvar i = 0; i < N; i++) begin : g_pin
        // two flops, then polarity and use gate
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                meta_r[i] <= 1'h0;
                sync_r[i] <= 1'h0;
                prev_r[i] <= 1'h0;
            end else begin
                meta_r[i] <= pin[i];
                sync_r[i] <= meta_r[i];
                prev_r[i] <= lvl[i];
            end
        end
        assign lvl[i] = (sync_r[i] ^ inv_sel[i]) & use_sel[i];
        assign sig.rise[i] = lvl[i] & ~prev_r[i];
        assign sig.fall[i] = ~lvl[i] & prev_r[i];
    end
    assign sig.lvl = lvl;
endmodule

/* qfc_axil.sv */
// axi4-lite slave front end, one write and one read in flight
`timescale 1ns/100ps
`include "qfc_regs.svh"
module qfc_axil (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`QFC_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [`QFC_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    qfc_reg_if.slave rg
);
    logic aw_got_r, w_got_r, rd_pend_r;
    logic [`QFC_ADDR_W-1:0] awaddr_r, araddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic aw_take, w_take, ar_take, do_wr;
    logic aw_got_nxt, w_got_nxt, bvalid_nxt, rvalid_nxt;

    // handshakes and next states
    assign aw_take = awvalid & awready;
    assign w_take = wvalid & wready;
    assign ar_take = arvalid & arready;
    assign do_wr = aw_got_r & w_got_r & ~bvalid;
    assign aw_got_nxt = do_wr ? 1'h0 : (aw_got_r | aw_take);
    assign w_got_nxt = do_wr ? 1'h0 : (w_got_r | w_take);
    assign bvalid_nxt = do_wr | (bvalid & ~bready);
    assign rvalid_nxt = rd_pend_r | (rvalid & ~rready);
    assign rg.wr = do_wr;
    assign rg.waddr = awaddr_r;
    assign rg.wdata = wdata_r;
    assign rg.wstrb = wstrb_r;
    assign rg.raddr = araddr_r;

    // write channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'h0;
            w_got_r <= 1'h0;
            awready <= 1'h0;
            wready <= 1'h0;
            bvalid <= 1'h0;
            bresp <= `QFC_RESP_OKAY;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else begin
            if (aw_take) awaddr_r <= awaddr;
            if (w_take) begin
                wdata_r <= wdata;
                wstrb_r <= wstrb;
            end
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            awready <= ~aw_got_nxt & ~bvalid_nxt;
            wready <= ~w_got_nxt & ~bvalid_nxt;
            bvalid <= bvalid_nxt;
            if (do_wr) bresp <= rg.werr ? `QFC_RESP_SLVERR : `QFC_RESP_OKAY;
        end
    end

    // read channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_pend_r <= 1'h0;
            arready <= 1'h0;
            rvalid <= 1'h0;
            rdata <= '0;
            rresp <= `QFC_RESP_OKAY;
            araddr_r <= '0;
        end else begin
            if (ar_take) araddr_r <= araddr;
            rd_pend_r <= ar_take;
            rvalid <= rvalid_nxt;
            arready <= ~ar_take & ~rd_pend_r & ~rvalid_nxt;
            if (rd_pend_r) begin
                rdata <= rg.rdata;
                rresp <= rg.rerr ? `QFC_RESP_SLVERR : `QFC_RESP_OKAY;
            end
        end
    end
endmodule

/* qfc_top.sv */
// quadrature fast counter: decode, count, compare, registers and interrupt
`timescale 1ns/100ps
`include "qfc_regs.svh"

// How it works
// - A leading B counts up, lagging down
// - x1: A rise up, A fall down
// - x2: both A edges count
// - x3: both A edges plus one B edge
// - x4: every A and B edge counts
// - effective mask and clear are OR of sources
// - unit set as counter or timer
// - eight modes; unassigned unit stays idle
// - each input enabled or unused individually
// - counting inputs invertible, default not
// - mask and clear inputs invertible, default not
// - fixed dedicated pins per signal
// - roles: pulse/direction or up/down pulses
// - mask freezes counting and preset writes
// - clear holds zero, restart from zero
// - interrupt when count reaches preset
// - 32-bit count or 16-bit count plus timer
module qfc_top
    import qfc_pkg::*;
#(
    parameter int CNT_W = 32,
    parameter int TICK_CYC = `QFC_TICK_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`QFC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`QFC_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic in_a,
    input wire logic in_b,
    input wire logic in_mask,
    input wire logic in_clear,
    output logic irq
);
    localparam int HW = `QFC_HALF_W;
    localparam int TICK_W = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;

    // the counter occupies one bus word and splits in two halves
    if (CNT_W != 32 || TICK_CYC < 1) begin : g_chk
        $error("qfc_top: CNT_W must be 32 and TICK_CYC at least 1");
    end

    qfc_pin_if pins ();
    qfc_reg_if rg ();

    logic [31:0] ctrl_r;
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic [CNT_W-1:0] preset_r;
    logic status_r;
    logic irq_mask_r;
    logic eq_prev_r;
    logic [TICK_W-1:0] tick_cnt_r;
    logic tick_r;

    logic assigned, timer_sel, len16, soft_mask_bit, soft_clear_bit;
    qfc_mode_e mode;
    logic [`QFC_PINS-1:0] use_sel, inv_sel;
    logic eff_mask, eff_clear;
    logic a_lvl, b_lvl, a_rise, a_fall, b_rise, b_fall;
    logic step_up, step_dn;
    logic [CNT_W-1:0] delta, stepped;
    logic eq_now, match_evt;
    logic wr_ctrl, wr_count, wr_preset, wr_status, wr_irq_mask;

    // byte-lane merge of a bus write into a register
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) res[i*8 +: 8] = nw[i*8 +: 8];
        end
        return res;
    endfunction

    // control fields
    assign assigned = ctrl_r[`QFC_CTRL_ASSIGN];
    assign mode = qfc_mode_e'(ctrl_r[`QFC_CTRL_MODE_MSB:`QFC_CTRL_MODE_LSB]);
    assign timer_sel = ctrl_r[`QFC_CTRL_TIMER];
    assign len16 = ctrl_r[`QFC_CTRL_LEN16];
    assign soft_mask_bit = ctrl_r[`QFC_CTRL_SMASK];
    assign soft_clear_bit = ctrl_r[`QFC_CTRL_SCLEAR];
    assign use_sel = ctrl_r[`QFC_CTRL_USE_MSB:`QFC_CTRL_USE_LSB];
    assign inv_sel = ctrl_r[`QFC_CTRL_INV_MSB:`QFC_CTRL_INV_LSB];

    // bus slave front end
    qfc_axil u_axil (
        .aclk (aclk),
        .aresetn (aresetn),
        .awaddr (s_axi_awaddr),
        .awvalid (s_axi_awvalid),
        .awready (s_axi_awready),
        .wdata (s_axi_wdata),
        .wstrb (s_axi_wstrb),
        .wvalid (s_axi_wvalid),
        .wready (s_axi_wready),
        .bresp (s_axi_bresp),
        .bvalid (s_axi_bvalid),
        .bready (s_axi_bready),
        .araddr (s_axi_araddr),
        .arvalid (s_axi_arvalid),
        .arready (s_axi_arready),
        .rdata (s_axi_rdata),
        .rresp (s_axi_rresp),
        .rvalid (s_axi_rvalid),
        .rready (s_axi_rready),
        .rg (rg.slave)
    );

    // fixed pins: a, b, mask, clear
    qfc_cond #(.N(`QFC_PINS)) u_cond (
        .aclk (aclk),
        .aresetn (aresetn),
        .pin ({in_clear, in_mask, in_b, in_a}),
        .use_sel (use_sel),
        .inv_sel (inv_sel),
        .sig (pins.cond)
    );

    assign a_lvl = pins.lvl[`QFC_PIN_A];
    assign b_lvl = pins.lvl[`QFC_PIN_B];
    assign a_rise = pins.rise[`QFC_PIN_A];
    assign a_fall = pins.fall[`QFC_PIN_A];
    assign b_rise = pins.rise[`QFC_PIN_B];
    assign b_fall = pins.fall[`QFC_PIN_B];

    // hardware level or software bit; unused pins read as zero
    assign eff_mask = pins.lvl[`QFC_PIN_M] | soft_mask_bit;
    assign eff_clear = pins.lvl[`QFC_PIN_C] | soft_clear_bit;

    // counting direction per mode
    always_comb begin
        step_up = 1'h0;
        step_dn = 1'h0;
        case (mode)
            updn_rise_mode: begin
                step_up = a_rise;
                step_dn = b_rise;
            end
            updn_both_mode: begin
                step_up = a_rise | a_fall;
                step_dn = b_rise | b_fall;
            end
            pdir_rise_mode: begin
                step_up = a_rise & ~b_lvl;
                step_dn = a_rise & b_lvl;
            end
            pdir_both_mode: begin
                step_up = (a_rise | a_fall) & ~b_lvl;
                step_dn = (a_rise | a_fall) & b_lvl;
            end
            quad_x1_mode: begin
                step_up = a_rise & ~b_lvl;
                step_dn = a_fall & ~b_lvl;
            end
            quad_x2_mode: begin
                step_up = (a_rise & ~b_lvl) | (a_fall & b_lvl);
                step_dn = (a_rise & b_lvl) | (a_fall & ~b_lvl);
            end
            quad_x3_mode: begin
                step_up = (a_rise & ~b_lvl) | (a_fall & b_lvl) | (b_rise & a_lvl);
                step_dn = (a_rise & b_lvl) | (a_fall & ~b_lvl) | (b_fall & a_lvl);
            end
            quad_x4_mode: begin
                step_up = (a_rise & ~b_lvl) | (a_fall & b_lvl) |
                    (b_rise & a_lvl) | (b_fall & ~a_lvl);
                step_dn = (a_rise & b_lvl) | (a_fall & ~b_lvl) |
                    (b_rise & ~a_lvl) | (b_fall & a_lvl);
            end
            default: begin
                step_up = 1'h0;
                step_dn = 1'h0;
            end
        endcase
    end

    // plus one, minus one, or nothing when both cancel
    always_comb begin
        delta = '0;
        if (timer_sel) begin
            delta = {{(CNT_W-1){1'h0}}, tick_r};
        end else if (step_up && !step_dn) begin
            delta = {{(CNT_W-1){1'h0}}, 1'h1};
        end else if (step_dn && !step_up) begin
            delta = '1;
        end
    end
    assign stepped = count_r + delta;

    // register strobes
    assign wr_ctrl = rg.wr && (rg.waddr == `QFC_OFS_CTRL);
    assign wr_count = rg.wr && (rg.waddr == `QFC_OFS_COUNT);
    assign wr_preset = rg.wr && (rg.waddr == `QFC_OFS_PRESET);
    assign wr_status = rg.wr && (rg.waddr == `QFC_OFS_STATUS);
    assign wr_irq_mask = rg.wr && (rg.waddr == `QFC_OFS_IRQ_MASK);
    assign rg.werr = !qfc_addr_known(rg.waddr);
    assign rg.rerr = !qfc_addr_known(rg.raddr);

    // next count: clear, then load, then masked or idle hold, then step
    always_comb begin
        count_nxt = count_r;
        if (eff_clear) begin
            count_nxt = '0;
        end else if (wr_count) begin
            count_nxt = merge(count_r, rg.wdata, rg.wstrb);
        end else if (eff_mask || !assigned) begin
            count_nxt = count_r;
        end else if (timer_sel) begin
            count_nxt = stepped;
        end else if (len16) begin
            count_nxt = {count_r[CNT_W-1:HW] + {{(CNT_W-HW-1){1'h0}}, tick_r},
                stepped[HW-1:0]};
        end else begin
            count_nxt = stepped;
        end
    end

    // count register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    // timer tick divider
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt_r <= '0;
            tick_r <= 1'h0;
        end else if (tick_cnt_r == TICK_W'(TICK_CYC - 1)) begin
            tick_cnt_r <= '0;
            tick_r <= 1'h1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 1'h1;
            tick_r <= 1'h0;
        end
    end

    // control and configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= `QFC_CTRL_RESET;
            irq_mask_r <= 1'h0;
        end else begin
            if (wr_ctrl) ctrl_r <= merge(ctrl_r, rg.wdata, rg.wstrb);
            if (wr_irq_mask && rg.wstrb[0]) irq_mask_r <= rg.wdata[`QFC_ST_MATCH];
        end
    end

    // preset is frozen while masked
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            preset_r <= '0;
        end else if (wr_preset && !eff_mask) begin
            preset_r <= merge(preset_r, rg.wdata, rg.wstrb);
        end
    end

    // comparator: event on the cycle count first equals preset
    assign eq_now = len16 ? (count_r[HW-1:0] == preset_r[HW-1:0]) : (count_r == preset_r);
    assign match_evt = assigned && eq_now && !eq_prev_r;

    // sticky status, set wins over write-one clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            eq_prev_r <= 1'h1;
            status_r <= 1'h0;
        end else begin
            eq_prev_r <= eq_now;
            if (match_evt) begin
                status_r <= 1'h1;
            end else if (wr_status && rg.wstrb[0] && rg.wdata[`QFC_ST_MATCH]) begin
                status_r <= 1'h0;
            end
        end
    end

    // level interrupt
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'h0;
        end else begin
            irq <= status_r & irq_mask_r;
        end
    end

    // read data mux
    always_comb begin
        rg.rdata = 32'h0000_0000;
        if (rg.raddr == `QFC_OFS_CTRL) begin
            rg.rdata = ctrl_r;
        end else if (rg.raddr == `QFC_OFS_COUNT) begin
            rg.rdata = count_r;
        end else if (rg.raddr == `QFC_OFS_PRESET) begin
            rg.rdata = preset_r;
        end else if (rg.raddr == `QFC_OFS_STATUS) begin
            rg.rdata[`QFC_ST_MATCH] = status_r;
            rg.rdata[`QFC_ST_MASK_LVL] = eff_mask;
            rg.rdata[`QFC_ST_CLEAR_LVL] = eff_clear;
        end else if (rg.raddr == `QFC_OFS_IRQ_MASK) begin
            rg.rdata[`QFC_ST_MATCH] = irq_mask_r;
        end
    end
endmodule

/* qfc_encoder_model.sv */
// quadrature encoder model driving the two phase inputs
`timescale 1ns/100ps
module qfc_encoder_model (
    input wire logic aclk,
    output logic pa,
    output logic pb
);
    logic [1:0] ph [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
    int p = 0;
    // both phases rest low
    initial begin
        pa = 1'b0;
        pb = 1'b0;
    end
    // one phase step per hold span, a leads b when turning up
    task automatic turn(input bit up, input int n, input int hold);
        repeat (n * 4) begin
            p = up ? (p + 1) % 4 : (p + 3) % 4;
            @(posedge aclk);
            {pa, pb} <= ph[p];
            repeat (hold - 1) @(posedge aclk);
        end
    endtask
endmodule

/* qfc_checker.sv */
// bus handshake and interrupt checks on the fast counter top
`timescale 1ns/100ps
module qfc_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // write data handshake, kept as one signal for the history checks
    logic w_hs;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    // completed request handshakes
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // answers, one transfer in flight
    a_write_answer: assert property (s_wr_taken |-> ##[1:3] s_axi_bvalid)
        else $error("write response missing");
    a_read_answer: assert property (s_rd_taken |-> ##[1:3] s_axi_rvalid)
        else $error("read response missing");
    a_aw_one_flight: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("second write address accepted");
    a_ar_one_flight: assert property (s_rd_taken |=> !s_axi_arready)
        else $error("second read address accepted");
    a_b_drops: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_r_drops: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response repeated");
    a_unmapped_read: assert property (s_rd_taken ##0 s_axi_araddr > 8'h10 |->
        ##[1:3] (s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0))
        else $error("unmapped read not refused");
    a_irq_sticky: assert property ($fell(irq) |-> $past(w_hs, 2) || $past(w_hs, 3) ||
        $past(w_hs, 4))
        else $error("interrupt dropped without a write");
endmodule
bind qfc_top qfc_checker u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));

/* quadrature_fast_counter_test.sv */
// self-checking bench for the quadrature fast counter
`timescale 1ns/100ps
`include "qfc_regs.svh"
module quadrature_fast_counter_test import qfc_pkg::*;;
    typedef struct {qfc_mode_e m; logic [3:0] iv; bit up; int k;} qfc_row_s;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, in_mask = 1'b0, in_clear = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awready, wready, bvalid, arready, rvalid, irq, pa, pb;
    logic [1:0] bresp, rresp;
    int err_count = 0;
    int checks = 0;
    // mode, inversion, direction, counts per encoder cycle
    qfc_row_s rows[12] = '{'{quad_x1_mode, 4'h0, 1, 1}, '{quad_x1_mode, 4'h0, 0, -1},
        '{quad_x2_mode, 4'h0, 1, 2}, '{quad_x2_mode, 4'h0, 0, -2},
        '{quad_x3_mode, 4'h0, 1, 3}, '{quad_x3_mode, 4'h0, 0, -3},
        '{quad_x4_mode, 4'h0, 1, 4}, '{quad_x4_mode, 4'h0, 0, -4},
        '{updn_rise_mode, 4'h0, 1, 0}, '{pdir_rise_mode, 4'h0, 1, 1},
        '{pdir_rise_mode, 4'h0, 0, -1}, '{quad_x4_mode, 4'h1, 1, -4}};
    always #2.5 aclk = ~aclk;
    qfc_top #(.TICK_CYC(4)) u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .in_a(pa), .in_b(pb),
        .in_mask(in_mask), .in_clear(in_clear), .irq(irq));
    qfc_encoder_model u_enc (.aclk(aclk), .pa(pa), .pb(pb));
    // control word: unit assigned, software bits in x
    function automatic logic [31:0] ctl(input logic [2:0] m, input logic [3:0] u,
        input logic [3:0] iv, input logic [3:0] x);
        return {16'h0000, iv, u, x, m, 1'b1};
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // bus write, both channels offered together
    task automatic axw(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] r);
        bit aw, w;
        aw = 0;
        w = 0;
        @(posedge aclk);
        awaddr <= ad;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (awready && !aw) begin
                aw = 1;
                awvalid <= 1'b0;
            end
            if (wready && !w) begin
                w = 1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        logic [1:0] r;
        axw(ad, d, r);
        chk({30'h0, r}, 32'h0);
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axr(ad, d, r);
        chk(d, e);
    endtask
    // configure, zero the count, turn the encoder, let the pipeline settle
    task automatic go(input logic [31:0] c, input bit up, input int n, input int h);
        wr(`QFC_OFS_CTRL, c);
        wr(`QFC_OFS_COUNT, 32'h0);
        u_enc.turn(up, n, h);
        repeat (6) @(posedge aclk);
    endtask
    task automatic end_sim;
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (30000) @(posedge aclk);
        err_count++;
        end_sim;
    end
    // main sequence
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0);
        for (int i = 0; i < 12; i++) begin
            go(ctl(rows[i].m, 4'h3, rows[i].iv, 4'h0), rows[i].up, 2, 3 + 5 * (i % 2));
            rd(`QFC_OFS_COUNT, 32'(rows[i].k * 2));
        end
        // both-edge pulse modes on one input
        go(ctl(updn_both_mode, 4'h2, 4'h0, 4'h0), 1, 1, 3);
        rd(`QFC_OFS_COUNT, 32'hFFFFFFFE);
        go(ctl(pdir_both_mode, 4'h1, 4'h0, 4'h0), 1, 1, 3);
        rd(`QFC_OFS_COUNT, 32'h2);
        // unmapped place refused
        axw(8'h14, 32'h1, r);
        chk({30'h0, r}, 32'h2);
        axr(8'h14, d, r);
        chk({d[29:0], r}, 32'h2);
        // mask sources and inversion
        in_mask <= 1'b1;
        go(ctl(quad_x4_mode, 4'h7, 4'h0, 4'h0), 1, 1, 3);
        rd(`QFC_OFS_COUNT, 32'h0);
        go(ctl(quad_x4_mode, 4'h3, 4'h0, 4'h0), 1, 1, 3);
        rd(`QFC_OFS_COUNT, 32'h4);
        in_mask <= 1'b0;
        go(ctl(quad_x4_mode, 4'h3, 4'h0, 4'h4), 1, 1, 3);
        rd(`QFC_OFS_COUNT, 32'h0);
        go(ctl(quad_x4_mode, 4'h7, 4'h4, 4'h0), 1, 1, 3);
        rd(`QFC_OFS_COUNT, 32'h0);
        // clear sources, restart from zero
        in_clear <= 1'b1;
        go(ctl(quad_x4_mode, 4'hB, 4'h0, 4'h0), 1, 1, 3);
        rd(`QFC_OFS_COUNT, 32'h0);
        in_clear <= 1'b0;
        repeat (4) @(posedge aclk);
        u_enc.turn(1, 1, 3);
        repeat (6) @(posedge aclk);
        rd(`QFC_OFS_COUNT, 32'h4);
        go(ctl(quad_x4_mode, 4'h3, 4'h0, 4'h8), 1, 1, 3);
        rd(`QFC_OFS_COUNT, 32'h0);
        go(ctl(quad_x4_mode, 4'h3, 4'h0, 4'h0) & 32'hFFFFFFFE, 1, 1, 3);
        rd(`QFC_OFS_COUNT, 32'h0);
        go(ctl(quad_x4_mode, 4'h3, 4'h0, 4'h2), 0, 1, 3);
        axr(`QFC_OFS_COUNT, d, r);
        chk({16'h0, d[15:0]}, 32'h0000FFFC);
        go(ctl(quad_x4_mode, 4'h0, 4'h0, 4'h1), 1, 0, 3);
        repeat (40) @(posedge aclk);
        axr(`QFC_OFS_COUNT, d, r);
        chk({31'h0, (d >= 8 && d <= 16) === 1'b1}, 32'h1);
        // match interrupt, cleared and masked
        wr(`QFC_OFS_PRESET, 32'h6);
        wr(`QFC_OFS_STATUS, 32'h1);
        wr(`QFC_OFS_IRQ_MASK, 32'h1);
        go(ctl(quad_x4_mode, 4'h3, 4'h0, 4'h0), 1, 2, 3);
        chk({31'h0, irq}, 32'h1);
        rd(`QFC_OFS_STATUS, 32'h1);
        wr(`QFC_OFS_STATUS, 32'h1);
        repeat (3) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        wr(`QFC_OFS_IRQ_MASK, 32'h0);
        go(ctl(quad_x4_mode, 4'h3, 4'h0, 4'h0), 1, 2, 8);
        rd(`QFC_OFS_STATUS, 32'h1);
        chk({31'h0, irq}, 32'h0);
        // reset in mid-run clears every register
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0);
        end_sim;
    end
endmodule
